/* File: udl_top.sv */
`timescale 1ns/1ps
// Function
// R1: Built-in default table is fixed content with no write path.
// R2: Store programmer recomputes checksum over words 03h-04h after ID changes.
// R3: Fall back to built-in table on blank store, bad checksum or first byte FFh.
// R4: Stored words are 16 bits, first byte low, second byte high.
// R5: Remote wake flag in word 05h high byte drives attribute bit D5.
// R6: Self-power strap sampled once at power-on drives attribute bit D6.
// R7: Attribute D7 always one, D4 to D0 always zero.
// R8: Max power from word 07h low byte bus-powered, high byte self-powered.
// R9: Max power counts 2 mA at high speed, 8 mA at SuperSpeed.
// R10: Configuration requests return the assembled attribute and max power fields.
// R11: High bytes of words 0Ah, 0Bh, 0Ch give the three string lengths.
// R12: Store programmer keeps string regions fixed, changing only lengths.
// R13: On losing external power, device status stops showing self-powered.
// R14: After power loss draw stays within reported value, else return to Powered.
// R15: Loaded fields and sampled power mode stay stable until next reset.
module udl_top (
   input wire logic CLK, // 25 MHz core clock
   input wire logic RST, // Async reset, active high
   input wire logic AWVALID, // AXI write address valid
   output logic AWREADY, // AXI write address ready
   input wire logic [7:0] AWADDR, // AXI write address
   input wire logic WVALID, // AXI write data valid
   output logic WREADY, // AXI write data ready
   input wire logic [31:0] WDATA, // AXI write data
   input wire logic [3:0] WSTRB, // AXI byte strobes
   output logic BVALID, // AXI write response valid
   input wire logic BREADY, // AXI write response ready
   output logic [1:0] BRESP, // AXI write response
   input wire logic ARVALID, // AXI read address valid
   output logic ARREADY, // AXI read address ready
   input wire logic [7:0] ARADDR, // AXI read address
   output logic RVALID, // AXI read data valid
   input wire logic RREADY, // AXI read data ready
   output logic [31:0] RDATA, // AXI read data
   output logic [1:0] RRESP, // AXI read response
   input wire logic SELF_POWER_STRAP, // Power mode strap
   input wire logic EXT_POWER_OK, // External supply present
   input wire logic BUS_RUN_OK, // Can run on bus power alone
   input wire logic SUPERSPEED, // Link in SuperSpeed, else high speed
   input wire logic STORE_VALID, // Store byte strobe
   input wire logic [7:0] STORE_BYTE, // Store byte, low byte of a word first
   input wire logic STORE_DONE, // Store read finished
   input wire logic DESC_REQ, // Descriptor request pulse
   input wire logic [7:0] DESC_TYPE, // Descriptor type
   input wire logic [7:0] DESC_INDEX, // Word index for string type
   output logic DESC_ACK, // Answer pulse
   output logic DESC_ERR, // Request refused
   output logic [15:0] DESC_DATA, // Answer word
   output logic [7:0] BM_ATTR, // Reported attributes
   output logic [7:0] MAX_POWER, // Reported max power
   output logic [11:0] DRAW_LIMIT_MA, // Bus current ceiling in mA
   output logic SELF_POWERED_STAT, // Device status self-powered bit
   output logic POWERED_RETURN, // Request return to Powered state
   output logic LOADED // Fields assembled
);
   udl_pkg::udl_state_e state;
   logic [15:0] tbl [0:udl_pkg::WORDS-1];
   logic [6:0] bcnt;
   logic [7:0] sum;
   logic [7:0] first;
   logic [5:0] cidx;
   logic from_ext;
   logic self_mode;
   logic strap_taken;
   logic desc_en;
   logic [7:0] len_prod, len_manu, len_ser;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_got, w_got;
   logic [31:0] rd_data;
   logic [1:0] rd_resp;
   logic store_good;
   logic store_take;
   udl_rom_if rom_bus ();

   udl_rom u_rom (
      .port (rom_bus.rom)
   );
   assign rom_bus.idx = cidx;

   // Word index of a string region entry
   function automatic logic is_str(input logic [7:0] i);
      is_str = (i >= {2'b00, udl_pkg::W_STR_LO}) && (i <= {2'b00, udl_pkg::W_LAST});
   endfunction : is_str

   // Bytes past the table end are dropped
   assign store_take = (state == udl_pkg::S_WAIT) && STORE_VALID
      && (bcnt != udl_pkg::BYTES_MAX);

   // A full image, non-blank first byte and matching checksum
   assign store_good = (bcnt == udl_pkg::BYTES_MAX) && (first != udl_pkg::BLANK_BYTE)
      && (8'(udl_pkg::CSUM_BASE - sum) == tbl[udl_pkg::W_CSUM][7:0]);

   // Strap caught once after reset release, never again
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         strap_taken <= 1'b0;
         self_mode <= 1'b0;
      end
      else if (!strap_taken)
      begin
         strap_taken <= 1'b1;
         // R6: strap sampled once
         self_mode <= SELF_POWER_STRAP;
      end
   end

   // Byte counter, first byte and checksum sum over the identity words
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         bcnt <= 7'h00;
         sum <= 8'h00;
         first <= 8'h00;
      end
      else if (store_take)
      begin
         bcnt <= 7'(bcnt + 7'h01);
         if (bcnt == 7'h00)
            first <= STORE_BYTE;
         if (bcnt[6:1] >= udl_pkg::W_SUM_LO && bcnt[6:1] <= udl_pkg::W_SUM_HI)
            sum <= 8'(sum + STORE_BYTE);
      end
   end

   // Table storage; no reset needed, nothing reads it before it is filled
   always_ff @(posedge CLK)
   begin
      if (store_take)
      begin
         // R4: first byte low, second byte high
         if (bcnt[0])
            tbl[bcnt[6:1]][15:8] <= STORE_BYTE;
         else
            tbl[bcnt[6:1]][7:0] <= STORE_BYTE;
      end
      else if (state == udl_pkg::S_COPY)
         tbl[cidx] <= rom_bus.word;
   end

   // Load sequencer: wait for the store, check it, copy defaults if needed
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state <= udl_pkg::S_WAIT;
         cidx <= 6'h00;
         from_ext <= 1'b0;
      end
      else
      begin
         case (state)
            udl_pkg::S_WAIT:
               if (STORE_DONE)
                  state <= udl_pkg::S_CHECK;
            udl_pkg::S_CHECK:
               // R3: blank, bad checksum or FFh first byte uses defaults
               if (store_good)
               begin
                  from_ext <= 1'b1;
                  state <= udl_pkg::S_BUILD;
               end
               else
               begin
                  cidx <= 6'h00;
                  state <= udl_pkg::S_COPY;
               end
            udl_pkg::S_COPY:
               if (cidx == udl_pkg::W_LAST)
                  state <= udl_pkg::S_BUILD;
               else
                  cidx <= 6'(cidx + 6'h01);
            udl_pkg::S_BUILD:
               state <= udl_pkg::S_READY;
            udl_pkg::S_READY:
               state <= udl_pkg::S_READY;
            default:
               state <= udl_pkg::S_WAIT;
         endcase
      end
   end

   // Assemble the descriptor fields once; they never change afterwards
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         BM_ATTR <= 8'h80;
         MAX_POWER <= 8'h00;
         len_prod <= 8'h00;
         len_manu <= 8'h00;
         len_ser <= 8'h00;
         LOADED <= 1'b0;
      end
      // R15: only the single build step writes these
      else if (state == udl_pkg::S_BUILD)
      begin
         // R7: D7 one, D4..D0 zero; R5: wake flag; R6: strap
         BM_ATTR <= {1'b1, self_mode, tbl[udl_pkg::W_CSUM][8 + udl_pkg::RWU_POS], 5'b00000};
         // R8: byte chosen by power mode
         MAX_POWER <= self_mode ? tbl[udl_pkg::W_MAXP][15:8] : tbl[udl_pkg::W_MAXP][7:0];
         // R11: string lengths from high bytes
         len_prod <= tbl[udl_pkg::W_LPROD][15:8];
         len_manu <= tbl[udl_pkg::W_LMANU][15:8];
         len_ser <= tbl[udl_pkg::W_LSER][15:8];
         LOADED <= 1'b1;
      end
   end

   // Power status and current ceiling; the ceiling follows the loaded max power and the live link speed
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         SELF_POWERED_STAT <= 1'b0;
         POWERED_RETURN <= 1'b0;
         DRAW_LIMIT_MA <= 12'h000;
      end
      else
      begin
         // R13: losing the supply clears the self-powered status
         SELF_POWERED_STAT <= strap_taken && self_mode && EXT_POWER_OK;
         // R14: cannot run on the bus alone, so go back to Powered
         POWERED_RETURN <= strap_taken && self_mode && !EXT_POWER_OK && !BUS_RUN_OK;
         // R9: 8 mA units at SuperSpeed, 2 mA at high speed
         if (SUPERSPEED)
            DRAW_LIMIT_MA <= {1'b0, MAX_POWER, 3'b000};
         else
            DRAW_LIMIT_MA <= {3'b000, MAX_POWER, 1'b0};
      end
   end

   // Descriptor answers one cycle after each request
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         DESC_ACK <= 1'b0;
         DESC_ERR <= 1'b0;
         DESC_DATA <= 16'h0000;
      end
      else
      begin
         DESC_ACK <= DESC_REQ;
         DESC_ERR <= 1'b0;
         DESC_DATA <= 16'h0000;
         if (DESC_REQ)
         begin
            // R10: configuration type returns max power and attributes
            if (!LOADED || !desc_en)
               DESC_ERR <= 1'b1;
            else if (DESC_TYPE == udl_pkg::TYPE_CONFIG)
               DESC_DATA <= {MAX_POWER, BM_ATTR};
            else if (DESC_TYPE == udl_pkg::TYPE_STRING && is_str(DESC_INDEX))
               DESC_DATA <= tbl[DESC_INDEX[5:0]];
            else
               DESC_ERR <= 1'b1;
         end
      end
   end

   // Register read decode; unmapped addresses answer DECERR
   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_resp = udl_pkg::RESP_OKAY;
      case (ARADDR)
         udl_pkg::ADDR_CTRL: rd_data = {31'h0000_0000, desc_en};
         udl_pkg::ADDR_STAT: rd_data = {26'h000_0000, POWERED_RETURN, SUPERSPEED,
            SELF_POWERED_STAT, self_mode, from_ext, LOADED};
         udl_pkg::ADDR_CFG: rd_data = {16'h0000, MAX_POWER, BM_ATTR};
         udl_pkg::ADDR_SLEN: rd_data = {8'h00, len_ser, len_manu, len_prod};
         default: rd_resp = udl_pkg::RESP_DECERR;
      endcase
   end

   // AXI read channel: one read at a time
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= udl_pkg::RESP_OKAY;
      end
      else if (ARVALID && ARREADY)
      begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RDATA <= rd_data;
         RRESP <= rd_resp;
      end
      else if (RVALID && RREADY)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
      end
   end

   // AXI write channels, address and data taken in either order
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= udl_pkg::RESP_OKAY;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            AWREADY <= 1'b0;
            aw_got <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (WVALID && WREADY)
         begin
            WREADY <= 1'b0;
            w_got <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (aw_got && w_got && !BVALID)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            BVALID <= 1'b1;
            // Read-only registers accept and ignore writes
            if (aw_addr == udl_pkg::ADDR_CTRL || aw_addr == udl_pkg::ADDR_STAT
               || aw_addr == udl_pkg::ADDR_CFG || aw_addr == udl_pkg::ADDR_SLEN)
               BRESP <= udl_pkg::RESP_OKAY;
            else
               BRESP <= udl_pkg::RESP_DECERR;
         end
         if (BVALID && BREADY)
         begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // Control register: the only software-writable state
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         desc_en <= udl_pkg::CTRL_EN_RST;
      // R1: no address reaches the default table
      else if (aw_got && w_got && !BVALID && aw_addr == udl_pkg::ADDR_CTRL && w_strb[0])
         desc_en <= w_data[0];
   end

   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   attr_fixed_a: assert property (LOADED |-> BM_ATTR[7] && BM_ATTR[4:0] == 5'b00000) // R7
      else $error("reserved attribute bits wrong");
   attr_self_a: assert property (LOADED |-> BM_ATTR[6] == self_mode) // R6
      else $error("self-powered attribute mismatch");
   wake_bit_a: assert property (LOADED |-> BM_ATTR[5] == tbl[5][8 + udl_pkg::RWU_POS]) // R5
      else $error("remote wake attribute mismatch");
   maxp_pick_a: assert property (LOADED |-> MAX_POWER == (self_mode ? tbl[7][15:8]
      : tbl[7][7:0])) // R8
      else $error("max power byte wrongly chosen");
   blank_fallback_a: assert property (state == udl_pkg::S_CHECK && first == 8'hFF
      |=> state == udl_pkg::S_COPY) // R3
      else $error("blank store not replaced by defaults");
   low_first_a: assert property (store_take && bcnt == 7'h00
      |=> tbl[0][7:0] == $past(STORE_BYTE)) // R4
      else $error("first byte not stored as low byte");
   fields_hold_a: assert property (LOADED |=> LOADED && $stable(BM_ATTR)
      && $stable(MAX_POWER) && $stable(self_mode)) // R15
      else $error("loaded fields changed");
   cfg_answer_a: assert property (DESC_REQ && DESC_TYPE == 8'h02 && LOADED && desc_en
      |=> DESC_ACK && !DESC_ERR && DESC_DATA == {MAX_POWER, BM_ATTR}) // R10
      else $error("configuration answer wrong");
   power_lost_a: assert property (!EXT_POWER_OK |=> !SELF_POWERED_STAT) // R13
      else $error("self-powered status kept after loss");
   ss_units_a: assert property (LOADED && SUPERSPEED
      |=> DRAW_LIMIT_MA == {1'b0, MAX_POWER, 3'b000}) // R9
      else $error("SuperSpeed current scale wrong");

   cover property (state == udl_pkg::S_COPY ##[1:60] LOADED);
   cover property (state == udl_pkg::S_CHECK && store_good ##2 LOADED);
   cover property (LOADED && DESC_REQ && DESC_TYPE == 8'h02 ##1 DESC_ACK);
   cover property (LOADED && self_mode && !EXT_POWER_OK ##1 POWERED_RETURN);
endmodule : udl_top

/* File: udl_pkg.sv */
package udl_pkg;
   // Word offsets inside the configuration table
   localparam logic [5:0] W_SUM_LO = 6'h03;
   localparam logic [5:0] W_SUM_HI = 6'h04;
   localparam logic [5:0] W_CSUM = 6'h05;
   localparam logic [5:0] W_MAXP = 6'h07;
   localparam logic [5:0] W_LPROD = 6'h0A;
   localparam logic [5:0] W_LMANU = 6'h0B;
   localparam logic [5:0] W_LSER = 6'h0C;
   localparam logic [5:0] W_STR_LO = 6'h0E;
   localparam logic [5:0] W_LAST = 6'h2C;
   localparam int WORDS = 45;
   localparam logic [6:0] BYTES_MAX = 7'h5A;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam logic [7:0] CSUM_BASE = 8'hFF;
   // Remote wake flag position within the high byte of the flag word
   localparam int RWU_POS = 0;
   // Identity words of the built-in table; values are arbitrary
   localparam logic [15:0] ROM_PID = 16'h1234;
   localparam logic [15:0] ROM_VID = 16'hABCD;
   localparam logic [15:0] ROM_NODE0 = 16'h0200;
   localparam logic [15:0] ROM_NODE2 = 16'h0100;
   // Descriptor request types
   localparam logic [7:0] TYPE_CONFIG = 8'h02;
   localparam logic [7:0] TYPE_STRING = 8'h03;
   // Register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_CFG = 8'h08;
   localparam logic [7:0] ADDR_SLEN = 8'h0C;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
   // Loader states
   typedef enum logic [2:0] {S_WAIT, S_CHECK, S_COPY, S_BUILD, S_READY} udl_state_e;
endpackage : udl_pkg

/* File: udl_rom_if.sv */
`timescale 1ns/1ps
interface udl_rom_if;
   logic [5:0] idx;
   logic [15:0] word;
   modport rom (input idx, output word);
   modport user (output idx, input word);
endinterface : udl_rom_if

/* File: udl_rom.sv */
`timescale 1ns/1ps
module udl_rom (
   udl_rom_if.rom port // Index in, fixed word out
);
   // Fixed table; there is deliberately no write path into it
   function automatic logic [15:0] rom_word(input logic [5:0] i);
      case (i)
         6'h00: rom_word = udl_pkg::ROM_NODE0;
         6'h02: rom_word = udl_pkg::ROM_NODE2;
         6'h03: rom_word = udl_pkg::ROM_PID;
         6'h04: rom_word = udl_pkg::ROM_VID;
         6'h05: rom_word = 16'h7341;
         6'h06: rom_word = 16'hE000;
         6'h07: rom_word = 16'h013E;
         6'h08: rom_word = 16'h0B80;
         6'h09: rom_word = 16'h0409;
         6'h0A: rom_word = 16'h070E;
         6'h0B: rom_word = 16'h101A;
         6'h0C: rom_word = 16'h0E26;
         6'h0D: rom_word = 16'h162D;
         6'h0E: rom_word = 16'h494E;
         6'h0F: rom_word = 16'h3043;
         6'h10: rom_word = 16'h3030;
         6'h11: rom_word = 16'h0031;
         6'h1A: rom_word = 16'h6547;
         6'h1B: rom_word = 16'h656E;
         6'h1C: rom_word = 16'h6972;
         6'h1D: rom_word = 16'h2063;
         6'h1E: rom_word = 16'h654E;
         6'h1F: rom_word = 16'h2074;
         6'h20: rom_word = 16'h6F43;
         6'h21: rom_word = 16'h7072;
         6'h26, 6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B: rom_word = 16'h3030;
         6'h2C: rom_word = 16'h3130;
         default: rom_word = 16'h0000;
      endcase
   endfunction : rom_word

   // Pure lookup, no state
   always_comb
   begin
      port.word = rom_word(port.idx);
   end
endmodule : udl_rom

/* File: udl_host_model.sv */
`timescale 1ns/1ps
// Host side of the descriptor port: one request at a time, one-cycle pulses
module udl_host_model (
   input wire logic CLK, // Core clock
   input wire logic DESC_ACK, // Answer pulse
   input wire logic DESC_ERR, // Refusal flag
   input wire logic [15:0] DESC_DATA, // Answer word
   output logic DESC_REQ, // Request pulse
   output logic [7:0] DESC_TYPE, // Descriptor type
   output logic [7:0] DESC_INDEX // Word index
);
   // Idle values from time zero
   initial
   begin
      DESC_REQ = 1'b0;
      DESC_TYPE = 8'h00;
      DESC_INDEX = 8'h00;
   end

   // descriptor request
   // Type and index are inverted once taken, so a stale value is never relied on
   task automatic ask(input logic [7:0] t, input logic [7:0] i, output logic e,
      output logic [15:0] d);
      int n;
      begin
         DESC_REQ <= 1'b1;
         DESC_TYPE <= t;
         DESC_INDEX <= i;
         @(posedge CLK);
         DESC_REQ <= 1'b0;
         DESC_TYPE <= ~t;
         DESC_INDEX <= ~i;
         e = 1'bx;
         d = 16'hXXXX;
         for (n = 0; n < 8; n++)
         begin
            @(posedge CLK);
            if (DESC_ACK === 1'b1)
            begin
               e = DESC_ERR;
               d = DESC_DATA;
               break;
            end
         end
      end
   endtask : ask
endmodule : udl_host_model

/* File: udl_bench.sv */
`timescale 1ns/1ps
module udl_bench;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, strap, ext_ok, bus_ok, ss;
   logic st_valid, st_done, req, ack, err, loaded, spwr, pret;
   logic [7:0] awaddr, araddr, st_byte, dtype, dindex, attr, maxp;
   logic [31:0] wdata, rdata, seed;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] ddata;
   logic [11:0] draw;
   logic [7:0] img [$];
   int mismatches, num_checks, cycles;

   udl_top u_udl_top (.CLK(clk), .RST(rst), .AWVALID(awvalid), .AWREADY(awready),
      .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
      .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
      .RDATA(rdata), .RRESP(rresp), .SELF_POWER_STRAP(strap), .EXT_POWER_OK(ext_ok),
      .BUS_RUN_OK(bus_ok), .SUPERSPEED(ss), .STORE_VALID(st_valid), .STORE_BYTE(st_byte),
      .STORE_DONE(st_done), .DESC_REQ(req), .DESC_TYPE(dtype), .DESC_INDEX(dindex),
      .DESC_ACK(ack), .DESC_ERR(err), .DESC_DATA(ddata), .BM_ATTR(attr), .MAX_POWER(maxp),
      .DRAW_LIMIT_MA(draw), .SELF_POWERED_STAT(spwr), .POWERED_RETURN(pret), .LOADED(loaded));

   udl_host_model u_udl_host_model (.CLK(clk), .DESC_ACK(ack), .DESC_ERR(err),
      .DESC_DATA(ddata), .DESC_REQ(req), .DESC_TYPE(dtype), .DESC_INDEX(dindex));

   // Free-running 25 MHz clock
   always #20 clk = ~clk;

   // Hang guard; five cases need well under this many cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         mismatches++;
         test_done();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic test_done;
      begin
         $display("Checks %0d mismatches %0d", num_checks, mismatches);
         if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask : test_done

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      begin
         num_checks++;
         if (seen !== exp)
         begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask : check

   // Ready on the response channels stays high, so no release is needed between accesses
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      begin
         awaddr <= a;
         wdata <= d;
         wstrb <= 4'hF;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         do
         begin
            @(posedge clk);
            if (awvalid && awready)
               awvalid <= 1'b0;
            if (wvalid && wready)
               wvalid <= 1'b0;
         end while (!(bvalid && bready));
         r = bresp;
      end
   endtask : axi_wr

   // No cycle limit of its own: only the hang guard ends a wait
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         do
         begin
            @(posedge clk);
            if (arvalid && arready)
               arvalid <= 1'b0;
         end while (!(rvalid && rready));
         d = rdata;
         r = rresp;
      end
   endtask : axi_rd

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      begin
         axi_rd(a, d, r);
         check(what, d, exp);
         check(what, r, er);
      end
   endtask : rdchk

   task automatic do_reset(input logic s, input logic sp);
      begin
         rst <= 1'b1;
         strap <= s;
         ss <= sp;
         ext_ok <= 1'b1;
         bus_ok <= 1'b1;
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         @(posedge clk);
      end
   endtask : do_reset

   task automatic store(input int n);
      int i;
      begin
         for (i = 0; i < n; i++)
         begin
            st_valid <= 1'b1;
            st_byte <= img[i];
            @(posedge clk);
         end
         st_valid <= 1'b0;
         st_done <= 1'b1;
         @(posedge clk);
         st_done <= 1'b0;
      end
   endtask : store

   // Kind: 0 partial store, 1 good with wake, 2 good without, 3 bad sum, 4 first byte FFh
   task automatic run_case(input logic s, input int kind);
      logic fb, e;
      logic [15:0] d, w07;
      logic [7:0] ea, em, fl;
      logic [23:0] lens;
      logic [1:0] r;
      int i;
      begin
         do_reset(s, kind[0]);
         u_udl_host_model.ask(udl_pkg::TYPE_CONFIG, 8'h00, e, d);
         check("early refuse", e, 1'b1);
         img.delete();
         for (i = 0; i < 90; i++)
         begin
            seed = lfsr(seed);
            img.push_back(seed[7:0]);
         end
         // first byte kept below 80h, so never the blank FFh
         img[0] = {1'b0, img[0][6:0]};
         img[11][udl_pkg::RWU_POS] = (kind == 1);
         img[10] = 8'hFF - img[6] - img[7] - img[8] - img[9] + ((kind == 3) ? 8'h01 : 8'h00);
         if (kind == 4)
            img[0] = 8'hFF;
         store((kind == 0) ? 10 : 90);
         for (i = 0; i < 100 && loaded !== 1'b1; i++)
            @(posedge clk);
         check("loaded", loaded, 1'b1);
         // Expected fields: built-in values unless the image is good
         fb = (kind == 0 || kind > 2);
         fl = fb ? 8'h73 : img[11];
         w07 = fb ? 16'h013E : {img[15], img[14]};
         lens = fb ? {8'h0E, 8'h10, 8'h07} : {img[25], img[23], img[21]};
         ea = {1'b1, s, fl[udl_pkg::RWU_POS], 5'h00};
         em = s ? w07[15:8] : w07[7:0];
         check("attr", attr, ea);
         check("maxp", maxp, em);
         u_udl_host_model.ask(udl_pkg::TYPE_CONFIG, 8'h00, e, d);
         check("cfg desc", {e, d}, {1'b0, em, ea});
         rdchk("cfg reg", udl_pkg::ADDR_CFG, {16'h0000, em, ea}, udl_pkg::RESP_OKAY);
         rdchk("slen", udl_pkg::ADDR_SLEN, {8'h00, lens}, udl_pkg::RESP_OKAY);
         rdchk("stat", udl_pkg::ADDR_STAT, {26'h0, 1'b0, ss, s, s, !fb, 1'b1},
            udl_pkg::RESP_OKAY);
         rdchk("unmapped", 8'h10, 32'h0000_0000, udl_pkg::RESP_DECERR);
         axi_wr(udl_pkg::ADDR_CFG, 32'hFFFF_FFFF, r);
         check("wr resp", r, udl_pkg::RESP_OKAY);
         axi_wr(8'h10, 32'hFFFF_FFFF, r);
         check("wr unmapped", r, udl_pkg::RESP_DECERR);
         rdchk("cfg no write", udl_pkg::ADDR_CFG, {16'h0000, em, ea}, udl_pkg::RESP_OKAY);
         for (i = 0; i < 2; i++)
         begin
            check("draw", draw, ss ? {1'b0, em, 3'b000} : {3'b000, em, 1'b0});
            ss <= ~ss;
            repeat (3) @(posedge clk);
         end
         for (i = udl_pkg::W_STR_LO; i <= udl_pkg::W_LAST && !fb; i++)
         begin
            u_udl_host_model.ask(udl_pkg::TYPE_STRING, i[7:0], e, d);
            check("string", {e, d}, {1'b0, img[2 * i + 1], img[2 * i]});
         end
         // Refused requests: index outside strings, unknown types
         for (i = 0; i < 4; i++)
         begin
            u_udl_host_model.ask((i < 2) ? udl_pkg::TYPE_STRING : 8'h02 + 8'(i),
               (i == 0) ? 8'h0D : 8'h2D, e, d);
            check("refuse", e, 1'b1);
         end
         axi_wr(udl_pkg::ADDR_CTRL, 32'h0000_0000, r);
         u_udl_host_model.ask(udl_pkg::TYPE_CONFIG, 8'h00, e, d);
         check("disabled", e, 1'b1);
         axi_wr(udl_pkg::ADDR_CTRL, 32'h0000_0001, r);
         u_udl_host_model.ask(udl_pkg::TYPE_CONFIG, 8'h00, e, d);
         check("enabled", {e, d}, {1'b0, em, ea});
         // Loss of external supply
         ext_ok <= 1'b0;
         bus_ok <= kind[1];
         repeat (3) @(posedge clk);
         check("self stat", spwr, 1'b0);
         check("return", pret, s && !kind[1]);
         check("draw held", draw, ss ? {1'b0, em, 3'b000} : {3'b000, em, 1'b0});
         ext_ok <= 1'b1;
         repeat (3) @(posedge clk);
         check("self back", spwr, s);
         // Strap flip and a late image after load change nothing
         strap <= ~s;
         img[0] = 8'h00;
         store(2);
         repeat (4) @(posedge clk);
         check("attr held", attr, ea);
         check("maxp held", maxp, em);
         $display("Test kind %0d strap %0d done", kind, s);
      end
   endtask : run_case

   // Main sequence
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      {awvalid, wvalid, arvalid, st_valid, st_done} = 5'h00;
      bready = 1'b1;
      rready = 1'b1;
      {strap, ss} = 2'b00;
      {ext_ok, bus_ok} = 2'b11;
      awaddr = 8'h00;
      araddr = 8'h00;
      st_byte = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      seed = 32'h0000_A301;
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      @(posedge clk);
      run_case(1'b0, 0);
      run_case(1'b1, 1);
      run_case(1'b0, 2);
      run_case(1'b1, 3);
      run_case(1'b0, 4);
      test_done();
   end
endmodule : udl_bench
